// file: dbssp_regs.svh
`ifndef DBSSP_REGS_SVH
`define DBSSP_REGS_SVH
// How it works
// R01: every write burst and every uncut read burst moves exactly four beats; a read burst cut by a latency switch moves three or five
// R02: read and write ports are separate, so both bursts may overlap in time
// R03: read and write commands sit on alternate link rising edges
// R04: link rise captures address, selects, and data plus masks of beats 1, 3
// R05: inverted link rise captures data plus masks of beats 2 and 4
// R06: each mask bit gates its byte lane for its own beat only
// R07: write data starts one cycle after the command; address is held till then
// R08: a write takes two link cycles; a new write before that is ignored
// R09: read beats 1 and 3 leave on inverted edges three and four, 2.5 cycles
// R10: read beats 2 and 4 leave on link rising edges four and five
// R11: a read takes two link cycles; a new read before that is ignored
// R12: complementary echo strobes toggle with every read beat, free running
// R13: output valid flag is high while read data is valid, aligned with echoes
// R14: bypass input low resets the delay loop and selects the shorter latency
// R15: address is ignored on edges where neither select is active
// R16: a read of a word being written returns the newest merged data
`define DBSSP_ADDR_W 4
`define DBSSP_DATA_W 36
`define DBSSP_LANES 4
`define DBSSP_LANE_W 9
`define DBSSP_BURST 4
`define DBSSP_WR_LAT_HALF 2
`define DBSSP_RD_LAT_HALF 5
`define DBSSP_RD_LAT_BYP_HALF 4
`define DBSSP_RD_PIPE 8
`define DBSSP_WR_PIPE 6
`define DBSSP_BUSY_HALF 3
`define DBSSP_FIFO_DEPTH 4
`define DBSSP_DLL_LOCK_EDGES 1024
`define DBSSP_RD_DATA_RST 36'h0_0000_0000
`endif

// file: dbssp_pkg.sv
`include "dbssp_regs.svh"
`default_nettype none
package dbssp_pkg;
  typedef struct packed {
    logic k;
    logic k_n;
    logic rd_sel_n;
    logic wr_sel_n;
    logic dll_bypass_n;
    logic [`DBSSP_ADDR_W-1:0] beat_location;
    logic [`DBSSP_DATA_W-1:0] data;
    logic [`DBSSP_LANES-1:0] mask_n;
  } dbssp_pin_type;

  typedef struct packed {
    logic [`DBSSP_ADDR_W-1:0] loc;
    logic [1:0] beat;
  } dbssp_word_type;

  typedef enum logic {
    DBSSP_LAT_DLL,
    DBSSP_LAT_BYPASS
  } dbssp_lat_type;
endpackage
`default_nettype wire

// file: dbssp_fifo.sv
`default_nettype none
module dbssp_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = store_q[rd_ptr_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      store_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: dbssp_port.sv
`include "dbssp_regs.svh"
`default_nettype none
module dbssp_port #(
  parameter int FIFO_DEPTH = `DBSSP_FIFO_DEPTH,
  parameter int DLL_LOCK_EDGES = `DBSSP_DLL_LOCK_EDGES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic rd_sel_n_i,
  input wire logic wr_sel_n_i,
  input wire logic dll_bypass_n_i,
  input wire logic [`DBSSP_ADDR_W-1:0] beat_location_i,
  input wire logic [`DBSSP_DATA_W-1:0] wr_data_i,
  input wire logic [`DBSSP_LANES-1:0] byte_lane_mask_n_i,
  output logic [`DBSSP_DATA_W-1:0] rd_data_o,
  output logic echo_strobe_true_o,
  output logic echo_strobe_compl_o,
  output logic output_valid_flag_o
);
  localparam int AW = `DBSSP_ADDR_W;
  localparam int DW = `DBSSP_DATA_W;
  localparam int LN = `DBSSP_LANES;
  localparam int LW = `DBSSP_LANE_W;
  localparam int WW = AW + 2;
  localparam int RDP = `DBSSP_RD_PIPE;
  localparam int WRP = `DBSSP_WR_PIPE;
  localparam int BL = `DBSSP_BURST;

  // byte lanes with a low mask bit take the new data, others keep the old
  function automatic logic [DW-1:0] lane_merge(
    input logic [DW-1:0] old_w,
    input logic [DW-1:0] new_w,
    input logic [LN-1:0] mask_n
  );
    logic [DW-1:0] res;
    res = old_w;
    for (int l = 0; l < LN; l++) begin
      if (!mask_n[l]) begin
        res[l*LW +: LW] = new_w[l*LW +: LW];
      end
    end
    return res;
  endfunction

  // idle levels for the sync stages: clocks start high so that a pin
  // already high at release is not taken for a rising edge
  localparam dbssp_pkg::dbssp_pin_type PIN_IDLE = '{k: 1'b1, k_n: 1'b1,
    rd_sel_n: 1'b1, wr_sel_n: 1'b1, dll_bypass_n: 1'b0,
    beat_location: '0, data: '0, mask_n: '1};

  dbssp_pkg::dbssp_pin_type pin_raw;
  dbssp_pkg::dbssp_pin_type pin_s1_q;
  dbssp_pkg::dbssp_pin_type pin_s2_q;
  dbssp_pkg::dbssp_lat_type mode_q;
  logic k_prev_q;
  logic kn_prev_q;
  logic k_rise;
  logic kn_rise;
  logic ev;
  logic rd_cmd;
  logic wr_cmd;
  logic [15:0] lock_cnt_q;
  logic dll_locked;
  logic [RDP-1:0] rd_pipe_q;
  logic [AW-1:0] rd_loc_q [RDP];
  logic [WRP-1:0] wr_pipe_q;
  logic [AW-1:0] wr_loc_q [WRP];
  logic [DW-1:0] mem_q [2**WW];
  logic wr_go;
  dbssp_pkg::dbssp_word_type wr_word;
  logic fetch_go;
  dbssp_pkg::dbssp_word_type fetch_word;
  logic out_go;
  logic [DW-1:0] fetch_data;
  logic fetch_pend_q;
  logic [DW-1:0] fetch_hold_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [DW-1:0] fifo_out_data;
  logic [DW-1:0] rd_data_q;
  logic echo_true_q;
  logic echo_compl_q;
  logic valid_q;

  // every pin is a foreign-domain input: two flops before any logic
  always_comb begin
    pin_raw.k = k_i;
    pin_raw.k_n = k_n_i;
    pin_raw.rd_sel_n = rd_sel_n_i;
    pin_raw.wr_sel_n = wr_sel_n_i;
    pin_raw.dll_bypass_n = dll_bypass_n_i;
    pin_raw.beat_location = beat_location_i;
    pin_raw.data = wr_data_i;
    pin_raw.mask_n = byte_lane_mask_n_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_q <= PIN_IDLE;
      pin_s2_q <= PIN_IDLE;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // data is synchronised alongside the clocks, so the value seen at the
  // detected edge is the one the far side held around that edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      k_prev_q <= 1'b1;
      kn_prev_q <= 1'b1;
    end else begin
      k_prev_q <= pin_s2_q.k;
      kn_prev_q <= pin_s2_q.k_n;
    end
  end

  assign k_rise = pin_s2_q.k & ~k_prev_q;
  assign kn_rise = pin_s2_q.k_n & ~kn_prev_q;
  assign ev = k_rise | kn_rise;

  // commands only on the true rising edge; a port still busy ignores one
  assign rd_cmd = k_rise & ~pin_s2_q.rd_sel_n
    & ~(|rd_pipe_q[`DBSSP_BUSY_HALF-1:0]); // [R03] [R04] [R11]
  assign wr_cmd = k_rise & ~pin_s2_q.wr_sel_n
    & ~(|wr_pipe_q[`DBSSP_BUSY_HALF-1:0]); // [R03] [R04] [R08]

  // bypass low holds the loop in reset; relock is counted in link edges
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_cnt_q <= '0;
    end else if (!pin_s2_q.dll_bypass_n) begin
      lock_cnt_q <= '0; // [R14]
    end else if (k_rise && !dll_locked) begin
      lock_cnt_q <= lock_cnt_q + 16'h0001;
    end
  end

  assign dll_locked = (lock_cnt_q == 16'(DLL_LOCK_EDGES));

  // latency may only change on a true edge, and that edge can fall in the middle of a burst
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= dbssp_pkg::DBSSP_LAT_BYPASS;
    end else if (k_rise) begin
      mode_q <= (pin_s2_q.dll_bypass_n && dll_locked)
        ? dbssp_pkg::DBSSP_LAT_DLL
        : dbssp_pkg::DBSSP_LAT_BYPASS; // [R14]
    end
  end

  // both pipes advance by one per half link cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_pipe_q <= '0;
      wr_pipe_q <= '0;
    end else if (ev) begin
      rd_pipe_q <= {rd_pipe_q[RDP-2:0], rd_cmd}; // [R02]
      wr_pipe_q <= {wr_pipe_q[WRP-2:0], wr_cmd}; // [R02]
    end
  end

  // deselected edges leave the first address stage untouched; later stages shift on every event
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_loc_q[0] <= '0;
      wr_loc_q[0] <= '0;
    end else begin
      if (rd_cmd) begin
        rd_loc_q[0] <= pin_s2_q.beat_location; // [R15]
      end
      if (wr_cmd) begin
        wr_loc_q[0] <= pin_s2_q.beat_location; // [R07] [R15]
      end
    end
  end

  for (genvar i = 1; i < RDP; i++) begin : g_rd_loc
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        rd_loc_q[i] <= '0;
      end else if (ev) begin
        rd_loc_q[i] <= rd_loc_q[i-1];
      end
    end
  end

  for (genvar i = 1; i < WRP; i++) begin : g_wr_loc
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        wr_loc_q[i] <= '0;
      end else if (ev) begin
        wr_loc_q[i] <= wr_loc_q[i-1];
      end
    end
  end

  // write beat j lands on half edge wr_lat + j after its command, so
  // beats 1 and 3 fall on true edges and 2 and 4 on inverted ones
  always_comb begin
    wr_go = 1'b0;
    wr_word = '0;
    for (int j = 0; j < BL; j++) begin
      if (wr_pipe_q[`DBSSP_WR_LAT_HALF - 1 + j]) begin
        wr_go = ev; // [R01] [R04] [R05] [R07]
        wr_word.loc = wr_loc_q[`DBSSP_WR_LAT_HALF - 1 + j];
        wr_word.beat = 2'(j);
      end
    end
  end

  // read words are fetched one half cycle before they leave
  always_comb begin
    fetch_go = 1'b0;
    fetch_word = '0;
    out_go = 1'b0;
    for (int j = 0; j < BL; j++) begin
      if (mode_q == dbssp_pkg::DBSSP_LAT_DLL) begin
        if (rd_pipe_q[`DBSSP_RD_LAT_HALF - 2 + j]) begin
          fetch_go = ev; // [R01]
          fetch_word.loc = rd_loc_q[`DBSSP_RD_LAT_HALF - 2 + j];
          fetch_word.beat = 2'(j);
        end
        if (rd_pipe_q[`DBSSP_RD_LAT_HALF - 1 + j]) begin
          out_go = ev; // [R09] [R10]
        end
      end else begin
        if (rd_pipe_q[`DBSSP_RD_LAT_BYP_HALF - 2 + j]) begin
          fetch_go = ev; // [R14]
          fetch_word.loc = rd_loc_q[`DBSSP_RD_LAT_BYP_HALF - 2 + j];
          fetch_word.beat = 2'(j);
        end
        if (rd_pipe_q[`DBSSP_RD_LAT_BYP_HALF - 1 + j]) begin
          out_go = ev; // [R14]
        end
      end
    end
  end

  // array storage kept reset-free: it is data, not control
  always_ff @(posedge clk_i) begin
    if (wr_go) begin
      mem_q[wr_word] <= lane_merge(mem_q[wr_word], pin_s2_q.data,
        pin_s2_q.mask_n); // [R06]
    end
  end

  // a beat written on the same edge as the fetch is forwarded
  always_comb begin
    fetch_data = mem_q[fetch_word];
    if (wr_go && wr_word == fetch_word) begin
      fetch_data = lane_merge(mem_q[fetch_word], pin_s2_q.data,
        pin_s2_q.mask_n); // [R16]
    end
  end

  // fetched word waits here while the buffer is full
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fetch_pend_q <= 1'b0;
      fetch_hold_q <= '0;
    end else if (fetch_go) begin
      fetch_pend_q <= 1'b1;
      fetch_hold_q <= fetch_data; // [R16]
    end else if (fifo_in_ready) begin
      fetch_pend_q <= 1'b0;
    end
  end

  assign fifo_out_ready = out_go;

  dbssp_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(fetch_pend_q),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fetch_hold_q),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // read data changes only on half-edge events and then stands
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_q <= `DBSSP_RD_DATA_RST;
    end else if (out_go && fifo_out_valid) begin
      rd_data_q <= fifo_out_data; // [R09] [R10]
    end
  end

  // valid follows each event so it lines up with the echo edges
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      valid_q <= 1'b0;
    end else if (ev) begin
      valid_q <= out_go & fifo_out_valid; // [R13]
    end
  end

  // echoes run free: high after inverted edges, low after true edges
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      echo_true_q <= 1'b0;
      echo_compl_q <= 1'b1;
    end else if (ev) begin
      echo_true_q <= kn_rise; // [R12]
      echo_compl_q <= k_rise; // [R12]
    end
  end

  assign rd_data_o = rd_data_q;
  assign echo_strobe_true_o = echo_true_q;
  assign echo_strobe_compl_o = echo_compl_q;
  assign output_valid_flag_o = valid_q;
endmodule
`default_nettype wire

// file: dbssp_port_sva.sv
`include "dbssp_regs.svh"
`default_nettype none
module dbssp_port_chk (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic rd_sel_n_i,
  input wire logic [`DBSSP_DATA_W-1:0] rd_data_o,
  input wire logic echo_strobe_true_o,
  input wire logic echo_strobe_compl_o,
  input wire logic output_valid_flag_o
);
  logic k_q;
  logic acc;
  logic [4:0] rgap_q;
  logic [5:0] since_q;
  logic [6:0] vcnt_q;
  // a read the port must take: select low at a k rise, port not busy
  assign acc = k_i && !k_q && !rd_sel_n_i && rgap_q >= 5'h0C;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      k_q <= 1'b0;
      rgap_q <= 5'h1F;
      since_q <= 6'h3F;
      vcnt_q <= 7'h00;
    end else begin
      k_q <= k_i;
      rgap_q <= acc ? 5'h00 : rgap_q + {4'h0, rgap_q != 5'h1F};
      since_q <= acc ? 6'h00 : since_q + {5'h00, since_q != 6'h3F};
      vcnt_q <= output_valid_flag_o ? vcnt_q + 7'h01 : 7'h00;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_echo_pair;
    echo_strobe_compl_o == !echo_strobe_true_o;
  endproperty
  a_echo_pair: assert property (p_echo_pair)
    else $error("echo strobes not complementary");
  property p_echo_rise;
    $rose(k_n_i) |-> ##[2:6] $rose(echo_strobe_true_o);
  endproperty
  a_echo_rise: assert property (p_echo_rise)
    else $error("echo strobe did not rise after inverted clock");
  property p_echo_fall;
    $rose(k_i) && echo_strobe_true_o |-> ##[2:6] $fell(echo_strobe_true_o);
  endproperty
  a_echo_fall: assert property (p_echo_fall)
    else $error("echo strobe did not fall after true clock");
  property p_echo_half;
    $rose(echo_strobe_true_o) |-> ##4 $fell(echo_strobe_true_o);
  endproperty
  a_echo_half: assert property (p_echo_half)
    else $error("echo strobe high time wrong");
  property p_valid_align;
    $changed(output_valid_flag_o) |-> $changed(echo_strobe_true_o);
  endproperty
  a_valid_align: assert property (p_valid_align)
    else $error("valid flag moved off an echo edge");
  property p_data_hold;
    output_valid_flag_o && $stable(echo_strobe_true_o) |-> $stable(rd_data_o);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("read data changed inside a beat");
  property p_burst_len;
    $fell(output_valid_flag_o) |-> vcnt_q[3:0] == 4'h0 && vcnt_q != 7'h00;
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("valid run not a whole number of bursts");
  property p_rd_lat;
    acc |-> ##[19:25] output_valid_flag_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data late");
  property p_valid_cause;
    $rose(output_valid_flag_o) |-> since_q <= 6'h1A;
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("valid without a read command");
endmodule
bind dbssp_port dbssp_port_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .k_i(k_i), .k_n_i(k_n_i), .rd_sel_n_i(rd_sel_n_i), .rd_data_o(rd_data_o),
  .echo_strobe_true_o(echo_strobe_true_o),
  .echo_strobe_compl_o(echo_strobe_compl_o),
  .output_valid_flag_o(output_valid_flag_o));
`default_nettype wire

// file: dbssp_host_model.sv
`include "dbssp_regs.svh"
`default_nettype none
module dbssp_host_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [35:0] rd_data_i,
  input wire logic echo_i,
  input wire logic valid_i,
  output wire dbssp_pkg::dbssp_pin_type pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_q;
  logic rs_q, ws_q, byp_q, e_q, pend;
  logic [3:0] loc_q, m_q;
  logic [35:0] d_q;
  logic [35:0] rq[$];
  int cyc = 0, t_cmd = 0, lat = 0;
  assign pin_o = '{ph_q[2], !ph_q[2], rs_q, ws_q, byp_q, loc_q, d_q, m_q};
  // idle pin levels until the first command
  initial begin
    rs_q <= 1'b1;
    ws_q <= 1'b1;
    byp_q <= 1'b0;
    loc_q <= 4'h0;
    m_q <= 4'hF;
    d_q <= 36'h0;
    e_q <= 1'b0;
    pend = 1'b0;
  end
  // link clock runs free so the echo strobes keep toggling
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) ph_q <= 3'h0;
    else ph_q <= ph_q + 3'h1;
  end
  // capture each beat on an echo edge while valid, as a controller would
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    e_q <= echo_i;
    if (valid_i === 1'b1 && echo_i !== e_q) begin
      rq.push_back(rd_data_i);
      if (pend) begin
        lat = cyc - t_cmd;
        pend = 1'b0;
      end
    end
  end
  task automatic ev();
    do @(posedge clk_i); while (ph_q[1:0] != 2'h3);
  endtask
  task automatic align();
    do @(posedge clk_i); while (ph_q != 3'h3);
  endtask
  task automatic set_byp(input logic v);
    align();
    byp_q <= v;
  endtask
  task automatic rd_cmd(input logic [3:0] a);
    align();
    rs_q <= 1'b0;
    loc_q <= a;
    t_cmd = cyc;
    pend = 1'b1;
    ev();
    rs_q <= 1'b1;
    loc_q <= ~a;
  endtask
  task automatic wr(input logic [3:0] a, input logic [143:0] d,
                    input logic [15:0] m);
    align();
    ws_q <= 1'b0;
    loc_q <= a;
    ev();
    ws_q <= 1'b1;
    loc_q <= ~a;
    for (int i = 0; i < 4; i++) begin
      ev();
      d_q <= d[36*i+:36];
      m_q <= m[4*i+:4];
    end
    ev();
    d_q <= ~d_q;
    m_q <= ~m_q;
  endtask
endmodule
`default_nettype wire

// file: dbssp_port_test.sv
`default_nettype none
module dbssp_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [3:0] loc;
    logic [35:0] seed;
    logic [15:0] mask;
  } dbssp_row_type;
  dbssp_row_type rows [5] = '{'{4'h0, 36'h1_2345_6780, 16'h0000},
    '{4'hF, 36'hA_BCDE_F010, 16'h0000}, '{4'h0, 36'h5_5555_5550, 16'h1248},
    '{4'h7, 36'hF_FFFF_FFF0, 16'h0000}, '{4'h7, 36'h0_0000_0000, 16'hFFFF}};
  logic clk_i;
  logic rst_b_i;
  wire dbssp_pkg::dbssp_pin_type pin;
  logic [35:0] rd_data;
  logic echo_t, echo_c, valid;
  logic [35:0] mem [64];
  int n_mismatch = 0, tests_run = 0, cyc_n = 0;
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  dbssp_host_model host (.clk_i(clk_i), .rst_b_i(rst_b_i), .rd_data_i(rd_data),
    .echo_i(echo_t), .valid_i(valid), .pin_o(pin));
  dbssp_port #(.FIFO_DEPTH(4), .DLL_LOCK_EDGES(4)) DUT (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .k_i(pin.k), .k_n_i(pin.k_n),
    .rd_sel_n_i(pin.rd_sel_n), .wr_sel_n_i(pin.wr_sel_n),
    .dll_bypass_n_i(pin.dll_bypass_n), .beat_location_i(pin.beat_location),
    .wr_data_i(pin.data), .byte_lane_mask_n_i(pin.mask_n),
    .rd_data_o(rd_data), .echo_strobe_true_o(echo_t),
    .echo_strobe_compl_o(echo_c), .output_valid_flag_o(valid));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [35:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic expect_rd(input logic [3:0] a);
    int w = 0;
    while (host.rq.size() < 4 && w < 80) begin
      @(posedge clk_i);
      w++;
    end
    for (int i = 0; i < 4; i++)
      chk("read beat", mem[{a, 2'(i)}], host.rq.pop_front());
  endtask
  task automatic wr_row(input dbssp_row_type r);
    logic [143:0] d;
    for (int i = 0; i < 4; i++) begin
      d[36*i+:36] = r.seed + 36'(i);
      for (int j = 0; j < 4; j++)
        if (!r.mask[4*i+j]) mem[{r.loc, 2'(i)}][9*j+:9] = d[36*i+9*j+:9];
    end
    host.wr(r.loc, d, r.mask);
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("outputs in reset", 36'h2, {33'h0, echo_t, echo_c, valid});
    rst_b_i <= 1'b1;
    host.set_byp(1'b1);
    repeat (80) @(posedge clk_i);
    foreach (rows[i]) begin
      wr_row(rows[i]);
      host.rd_cmd(rows[i].loc);
      expect_rd(rows[i].loc);
    end
    chk("delay loop read latency", 36'h18, 36'(host.lat));
    $display("test rows done");
    // read one cycle before a write to the same word: each fetch meets
    // the write of the same beat, so the newest data must be forwarded
    fork
      host.rd_cmd(4'h5);
      begin
        @(negedge pin.rd_sel_n);
        wr_row('{4'h5, 36'h9_8765_4320, 16'h0000});
      end
    join
    expect_rd(4'h5);
    $display("test overlap done");
    host.rd_cmd(4'h0);
    host.rd_cmd(4'hF);
    expect_rd(4'h0);
    repeat (60) @(posedge clk_i);
    chk("beats after refused read", 36'h0, 36'(host.rq.size()));
    host.rd_cmd(4'h7);
    host.ev();
    host.ev();
    host.rd_cmd(4'hF);
    expect_rd(4'h7);
    expect_rd(4'hF);
    $display("test read spacing done");
    host.set_byp(1'b0);
    repeat (16) @(posedge clk_i);
    host.rd_cmd(4'h5);
    expect_rd(4'h5);
    chk("bypass read latency", 36'h14, 36'(host.lat));
    $display("test bypass done");
    wrap_up();
  end
endmodule
`default_nettype wire
